// ---- charger_i2c_pkg.sv ----
// Purpose: shared constants and types for the charger two-wire target port
// Assumes: 200 MHz system clock
// Notes: glitch and timeout counts derive from printed times and the clock period; STRAP_SETTLE is given in cycles
package charger_i2c_pkg;
   localparam int CLK_PERIOD_NS = 5;
   localparam int DEGLITCH_NS = 50;
   // longest pulse to reject, rounded down to whole cycles
   localparam int GLITCH_CYC = DEGLITCH_NS / CLK_PERIOD_NS;
   localparam int TIMEOUT_MS = 100;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int STRAP_SETTLE = 4;
   localparam logic [6:0] ADDR_OPT0 = 7'h24;
   localparam logic [6:0] ADDR_OPT1 = 7'h66;
   localparam logic RW_READ = 1'h1;
   localparam int NUM_REGS = 32;
   localparam int REG_W = 8;
   localparam logic [7:0] STATUS_IDX = 8'h06;
   localparam int FAULT_BIT = 0;
   localparam int CFG_FIRST = 8;
   localparam logic [7:0] BASIC_DEFAULT = 8'h00;
   localparam logic [7:0] CFG_DEFAULT0 = 8'h5A;
   localparam logic [7:0] CFG_DEFAULT1 = 8'hA5;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_INDEX, ST_WRITE, ST_READ, ST_IGNORE}
      i2c_state_type;
endpackage : charger_i2c_pkg

// ---- reg_bus_if.sv ----
// Purpose: register file access between the port engine and its storage
// Assumes: single sys_clk domain
// Notes: master is the serial engine, target is the register memory
`timescale 1ns/1ps
interface reg_bus_if #(parameter int IDX_W = 5, parameter int DATA_W = 8) ();
   logic wrEn;
   logic [IDX_W-1:0] wrIndex;
   logic [DATA_W-1:0] wrData;
   logic [IDX_W-1:0] rdIndex;
   logic [DATA_W-1:0] rdData;
   logic loadDefaults;
   logic variant;
   modport master(output wrEn, wrIndex, wrData, rdIndex, loadDefaults, variant, input rdData);
   modport target(input wrEn, wrIndex, wrData, rdIndex, loadDefaults, variant, output rdData);
endinterface : reg_bus_if

// ---- reg_file_mem.sv ----
// Purpose: volatile register array with variant-dependent defaults
// Assumes: loadDefaults pulses once after reset release
// Notes: read data are registered, one cycle behind rdIndex
`timescale 1ns/1ps
module reg_file_mem
   import charger_i2c_pkg::*;
#(
   parameter int NUM = NUM_REGS,
   parameter int DATA_W = REG_W
) (
   input wire logic sys_clk, // system clock
   input wire logic rst, // async reset, active high
   reg_bus_if.target bus // access from the serial engine
);
   logic [DATA_W-1:0] mem_reg [NUM];
   logic [DATA_W-1:0] rdData_reg;

   genvar i;
   generate
      for (i = 0; i < NUM; i++) begin : g_entry
         // contents never outlive a power cycle
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               mem_reg[i] <= '0;
            end else if (bus.loadDefaults) begin
               if (i >= CFG_FIRST) begin
                  mem_reg[i] <= bus.variant ? CFG_DEFAULT1 : CFG_DEFAULT0;
               end else begin
                  mem_reg[i] <= BASIC_DEFAULT;
               end
            end else if (bus.wrEn && bus.wrIndex == i) begin
               mem_reg[i] <= bus.wrData;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdData_reg <= '0;
      end else begin
         rdData_reg <= mem_reg[bus.rdIndex];
      end
   end
   assign bus.rdData = rdData_reg;

   cfg_default_a: assert property (@(posedge sys_clk) disable iff (rst)
      bus.loadDefaults |=> mem_reg[CFG_FIRST] == ($past(bus.variant) ? CFG_DEFAULT1 : CFG_DEFAULT0)
         && mem_reg[0] == BASIC_DEFAULT)
      else $error("defaults not loaded from variant");
endmodule : reg_file_mem

// ---- charger_i2c_slave_port.sv ----
// Purpose: two-wire serial target port of the charger register file
// Assumes: bus clock up to 1 MHz; external pull-up on the data line
// Notes: clock line is only sampled, never driven
`timescale 1ns/1ps
module charger_i2c_slave_port
   import charger_i2c_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   input wire logic sys_clk, // system clock
   input wire logic rst, // async reset, active high
   input wire logic sclIn, // serial clock pin
   input wire logic sdaIn, // serial data pin level
   output logic sdaOut, // data drive value, always low
   output logic sdaOe, // data drive enable, high pulls low
   input wire logic defaultConfigIndex, // factory variant strap
   input wire logic chargeResetState, // charger in reset state
   input wire logic supplyLossState, // supply loss or power-on reset
   input wire logic [REG_W-2:0] statusIn, // live status bits 7..1
   output logic busFault, // sticky timeout fault flag
   output logic regWrPulse, // register write happened
   output logic [7:0] regWrIndex, // index of that write
   output logic [REG_W-1:0] regWrData // data of that write
);
   localparam int IDX_W = $clog2(NUM_REGS);
   localparam int FW = $clog2(GLITCH_CYC + 1);
   localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

   reg_bus_if #(.IDX_W(IDX_W), .DATA_W(REG_W)) bus ();

   reg_file_mem #(.NUM(NUM_REGS), .DATA_W(REG_W)) u_mem (
      .sys_clk(sys_clk),
      .rst(rst),
      .bus(bus)
   );

   // line 0 clock, 1 data, 2 strap
   logic [2:0] syncA_reg, syncB_reg, syncC_reg;
   logic [1:0] fltOut_reg;
   logic [FW-1:0] fltCnt_reg [2];

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               syncA_reg[g] <= 1'h1;
               syncB_reg[g] <= 1'h1;
               syncC_reg[g] <= 1'h1;
            end else begin
               syncA_reg[g] <= (g == 0) ? sclIn : (g == 1) ? sdaIn : defaultConfigIndex;
               syncB_reg[g] <= syncA_reg[g];
               syncC_reg[g] <= syncB_reg[g];
            end
         end
      end
      for (g = 0; g < 2; g++) begin : g_filter
         // new level taken only after it outlasts the glitch window
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               fltOut_reg[g] <= 1'h1;
               fltCnt_reg[g] <= '0;
            end else if (syncB_reg[g] != syncC_reg[g] || syncC_reg[g] == fltOut_reg[g]) begin
               fltCnt_reg[g] <= '0;
            end else if (fltCnt_reg[g] == FW'(GLITCH_CYC)) begin
               fltOut_reg[g] <= syncC_reg[g];
               fltCnt_reg[g] <= '0;
            end else begin
               fltCnt_reg[g] <= fltCnt_reg[g] + FW'(1);
            end
         end
      end
   endgenerate

   // strap caught once it is stable after reset release
   logic [2:0] strapCnt_reg;
   logic initDone_reg;
   logic variant_reg;
   logic loadPulse;
   assign loadPulse = !initDone_reg && strapCnt_reg == 3'(STRAP_SETTLE);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         strapCnt_reg <= '0;
         initDone_reg <= 1'h0;
         variant_reg <= 1'h0;
      end else if (loadPulse) begin
         initDone_reg <= 1'h1;
         variant_reg <= syncC_reg[2];
      end else if (!initDone_reg) begin
         strapCnt_reg <= (syncB_reg[2] == syncC_reg[2]) ? strapCnt_reg + 3'h1 : '0;
      end
   end

   logic sclPrev_reg, sdaPrev_reg;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sclPrev_reg <= 1'h1;
         sdaPrev_reg <= 1'h1;
      end else begin
         sclPrev_reg <= fltOut_reg[0];
         sdaPrev_reg <= fltOut_reg[1];
      end
   end

   logic sclF, sdaF, sclRise, sclFall, startCond, stopCond, hold;
   assign sclF = fltOut_reg[0];
   assign sdaF = fltOut_reg[1];
   assign sclRise = sclF && !sclPrev_reg;
   assign sclFall = !sclF && sclPrev_reg;
   assign startCond = sclF && sclPrev_reg && sdaPrev_reg && !sdaF;
   assign stopCond = sclF && sclPrev_reg && !sdaPrev_reg && sdaF;
   assign hold = chargeResetState || supplyLossState || !initDone_reg;

   i2c_state_type state_reg;
   logic [3:0] bitCnt_reg;
   logic ackPhase_reg;
   logic [7:0] rxShift_reg, txShift_reg, regIndex_reg;
   logic busy_reg, fault_reg, timeoutHit, byteDone, ackEnd, addrHit, inRange;
   logic [TW-1:0] timer_reg;
   logic [REG_W-1:0] readByte;

   assign byteDone = sclFall && bitCnt_reg == BITS_PER_BYTE && !ackPhase_reg;
   assign ackEnd = sclFall && ackPhase_reg;
   assign addrHit = rxShift_reg[7:1] == (variant_reg ? ADDR_OPT1 : ADDR_OPT0);
   assign inRange = regIndex_reg < 8'(NUM_REGS);
   assign timeoutHit = busy_reg && timer_reg == TW'(TIMEOUT_CYCLES - 1);
   // status register is assembled live; only the fault bit is held here
   assign readByte = !inRange ? '0 :
      (regIndex_reg == STATUS_IDX) ? {statusIn, fault_reg} : bus.rdData;

   assign bus.rdIndex = regIndex_reg[IDX_W-1:0];
   assign bus.wrIndex = regIndex_reg[IDX_W-1:0];
   assign bus.wrData = rxShift_reg;
   // status index refuses host writes
   assign bus.wrEn = byteDone && state_reg == ST_WRITE && !hold && inRange
      && regIndex_reg != STATUS_IDX;
   assign bus.loadDefaults = loadPulse;
   assign bus.variant = syncC_reg[2];
   assign sdaOut = 1'h0;
   assign busFault = fault_reg;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         bitCnt_reg <= '0;
         ackPhase_reg <= 1'h0;
         rxShift_reg <= '0;
         txShift_reg <= '0;
         regIndex_reg <= '0;
         sdaOe <= 1'h0;
      end else if (hold) begin
         state_reg <= ST_IDLE;
         ackPhase_reg <= 1'h0;
         sdaOe <= 1'h0;
      end else if (startCond) begin
         state_reg <= ST_ADDR;
         bitCnt_reg <= '0;
         ackPhase_reg <= 1'h0;
         sdaOe <= 1'h0;
      end else if (stopCond || timeoutHit) begin
         state_reg <= ST_IDLE;
         ackPhase_reg <= 1'h0;
         sdaOe <= 1'h0;
      end else if (state_reg != ST_IDLE && state_reg != ST_IGNORE) begin
         if (sclRise && !ackPhase_reg) begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
            rxShift_reg <= {rxShift_reg[6:0], sdaF};
         end
         if (sclRise && ackPhase_reg && state_reg == ST_READ && sdaF) begin
            state_reg <= ST_IGNORE; // host ended the read
         end
         if (byteDone) begin
            ackPhase_reg <= 1'h1;
            unique case (state_reg)
               ST_ADDR: begin
                  sdaOe <= addrHit;
                  state_reg <= !addrHit ? ST_IGNORE :
                     (rxShift_reg[0] == RW_READ) ? ST_READ : ST_INDEX;
               end
               ST_INDEX: begin
                  sdaOe <= 1'h1;
                  regIndex_reg <= rxShift_reg;
                  state_reg <= ST_WRITE;
               end
               ST_WRITE: begin
                  sdaOe <= 1'h1;
                  regIndex_reg <= regIndex_reg + 8'h1;
               end
               ST_READ: begin
                  sdaOe <= 1'h0;
                  regIndex_reg <= regIndex_reg + 8'h1;
               end
            endcase
         end
         if (ackEnd) begin
            ackPhase_reg <= 1'h0;
            bitCnt_reg <= '0;
            if (state_reg == ST_READ) begin
               txShift_reg <= readByte;
               sdaOe <= !readByte[7];
            end else begin
               sdaOe <= 1'h0;
            end
         end
         if (sclFall && !ackPhase_reg && state_reg == ST_READ && bitCnt_reg != '0
               && bitCnt_reg != BITS_PER_BYTE) begin
            txShift_reg <= {txShift_reg[6:0], 1'h0};
            sdaOe <= !txShift_reg[6];
         end
      end
   end

   // limit runs from start to stop; a silent bus never trips it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         busy_reg <= 1'h0;
         timer_reg <= '0;
      end else if (hold || stopCond || (timeoutHit && !startCond)) begin
         busy_reg <= 1'h0;
         timer_reg <= '0;
      end else if (startCond) begin
         busy_reg <= 1'h1;
         timer_reg <= '0;
      end else if (busy_reg) begin
         timer_reg <= timer_reg + TW'(1);
      end
   end

   // set wins over the clear-on-read of the status byte
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fault_reg <= 1'h0;
      end else if (timeoutHit) begin
         fault_reg <= 1'h1;
      end else if (!hold && ackEnd && state_reg == ST_READ && regIndex_reg == STATUS_IDX) begin
         fault_reg <= 1'h0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         regWrPulse <= 1'h0;
         regWrIndex <= '0;
         regWrData <= '0;
      end else begin
         regWrPulse <= bus.wrEn;
         if (bus.wrEn) begin
            regWrIndex <= regIndex_reg;
            regWrData <= rxShift_reg;
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   start_restart_a: assert property (startCond && !hold |=> state_reg == ST_ADDR
      && bitCnt_reg == '0 && !sdaOe) else $error("start did not restart decoding");
   chg_reset_a: assert property (chargeResetState |=> state_reg == ST_IDLE && !sdaOe)
      else $error("port active in charger reset");
   supply_loss_a: assert property (supplyLossState |=> state_reg == ST_IDLE)
      else $error("supply loss did not idle engine");
   timeout_fault_a: assert property (timeoutHit && !startCond && !hold
      |=> state_reg == ST_IDLE && busFault[*2]) else $error("timeout not handled");
   glitch_window_a: assert property ($changed(fltOut_reg[0]) |->
      $past(fltCnt_reg[0]) == FW'(GLITCH_CYC) && $past(syncC_reg[0]) == fltOut_reg[0])
      else $error("clock line accepted a short pulse");
   ignore_release_a: assert property (state_reg == ST_IGNORE |-> !sdaOe)
      else $error("data driven after foreign address");
   addr_miss_a: assert property (byteDone && state_reg == ST_ADDR && !addrHit && !hold
      |=> state_reg == ST_IGNORE && !sdaOe) else $error("foreign address acknowledged");
   addr_hit_a: assert property (byteDone && state_reg == ST_ADDR && addrHit && !hold
      |=> sdaOe && ackPhase_reg) else $error("own address not acknowledged");
   status_ro_a: assert property (byteDone && state_reg == ST_WRITE
      && regIndex_reg == STATUS_IDX |=> !regWrPulse) else $error("status register written");

   write_hit_c: cover property (byteDone && state_reg == ST_ADDR && addrHit && !rxShift_reg[0]);
   read_byte_c: cover property (ackEnd && state_reg == ST_READ);
   timeout_c: cover property (timeoutHit);
   host_nack_c: cover property (state_reg == ST_READ ##1 state_reg == ST_IGNORE);
endmodule : charger_i2c_slave_port

// ---- i2c_host_model.sv ----
// Purpose: bus master model driving the charger port's clock and data lines
// Assumes: driven at falling edges of sys_clk; pull-up resolved by the bench
// Notes: 1 MHz bit rate, clock low 600 ns, high 400 ns
`timescale 1ns/1ps
module i2c_host_model (
   input wire logic sys_clk, // system clock
   input wire logic sdaWire, // resolved data line
   output logic scl, // bus clock, idle high
   output logic sdaLow // high pulls data low
);
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : hold
   task automatic bit_cycle(input logic outBit, output logic inBit);
      hold(60);
      sdaLow = ~outBit;
      hold(60);
      scl = 1'b1;
      hold(40);
      inBit = sdaWire;
      hold(40);
      scl = 1'b0;
   endtask : bit_cycle
   // also serves as repeated start when the clock is low
   task automatic start();
      if (scl == 1'b0) begin
         hold(60);
         sdaLow = 1'b0;
         hold(60);
         scl = 1'b1;
      end
      hold(60);
      sdaLow = 1'b1;
      hold(60);
      scl = 1'b0;
   endtask : start
   task automatic stop();
      hold(60);
      sdaLow = 1'b1;
      hold(60);
      scl = 1'b1;
      hold(60);
      sdaLow = 1'b0;
      hold(60);
   endtask : stop
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic unused;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(b[i], unused);
      end
      bit_cycle(1'b1, ack);
   endtask : send_byte
   task automatic recv_byte(input logic nack, output logic [7:0] d);
      logic unused;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, d[i]);
      end
      bit_cycle(nack, unused);
   endtask : recv_byte
   // 50 ns clock pulse in mid-low; must not count as a bit
   task automatic glitch_scl();
      hold(60);
      scl = 1'b1;
      hold(10);
      scl = 1'b0;
   endtask : glitch_scl
endmodule : i2c_host_model

// ---- charger_i2c_slave_port_tb.sv ----
// Purpose: self-checking bench of the charger two-wire target port
// Assumes: shortened timeout parameter; host model on the far side
// Notes: data wire is the and of both pull-downs with a pull-up
`timescale 1ns/1ps
module charger_i2c_slave_port_tb;
   import charger_i2c_pkg::*;
   localparam int TO_CYC = 7000;
   logic sys_clk, rst, scl, sdaLow, sdaWire, sdaOut, sdaOe, strap, chgRst, supLoss;
   logic busFault, regWrPulse;
   logic outBad = 1'b0;
   int oeCount = 0;
   logic [7:0] regWrIndex, regWrData;
   logic [6:0] devAddr;
   int numErrors = 0;
   int compares = 0;
   int wrCount = 0;
   assign sdaWire = (sdaOe ? sdaOut : 1'b1) & ~sdaLow;
   i2c_host_model host_i (.sys_clk(sys_clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));
   charger_i2c_slave_port #(.TIMEOUT_CYCLES(TO_CYC)) charger_i2c_slave_port_i (
      .sys_clk(sys_clk), .rst(rst), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .defaultConfigIndex(strap), .chargeResetState(chgRst),
      .supplyLossState(supLoss), .statusIn(7'h55), .busFault(busFault),
      .regWrPulse(regWrPulse), .regWrIndex(regWrIndex), .regWrData(regWrData));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (regWrPulse === 1'b1) wrCount <= wrCount + 1;
      if (sdaOe === 1'b1) oeCount <= oeCount + 1;
      if (sdaOe === 1'b1 && sdaOut !== 1'b0) outBad <= 1'b1;
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      compares++;
      if (seen !== exp) begin
         numErrors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic do_reset(input logic variant);
      @(negedge sys_clk);
      rst = 1'b1;
      strap = variant;
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      repeat (40) @(negedge sys_clk);
   endtask : do_reset
   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] data);
      logic a0, a1, a2;
      host_i.start();
      host_i.send_byte({devAddr, 1'b0}, a0);
      host_i.send_byte(idx, a1);
      host_i.send_byte(data, a2);
      host_i.stop();
      check("write acks", 8'h00, {5'h00, a0, a1, a2});
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp);
      logic a0, a1, a2;
      logic [7:0] d;
      host_i.start();
      host_i.send_byte({devAddr, 1'b0}, a0);
      host_i.send_byte(idx, a1);
      host_i.start();
      host_i.send_byte({devAddr, RW_READ}, a2);
      host_i.recv_byte(1'b1, d);
      host_i.stop();
      check("read acks", 8'h00, {5'h00, a0, a1, a2});
      check("read data", exp, d);
   endtask : rd_reg
   // host acks the first byte, so the index must step on
   task automatic rd_pair(input logic [7:0] idx, input logic [7:0] exp0, input logic [7:0] exp1);
      logic a0, a1, a2;
      logic [7:0] d0, d1;
      host_i.start();
      host_i.send_byte({devAddr, 1'b0}, a0);
      host_i.send_byte(idx, a1);
      host_i.start();
      host_i.send_byte({devAddr, RW_READ}, a2);
      host_i.recv_byte(1'b0, d0);
      host_i.recv_byte(1'b1, d1);
      host_i.stop();
      check("burst acks", 8'h00, {5'h00, a0, a1, a2});
      check("burst first", exp0, d0);
      check("burst next", exp1, d1);
   endtask : rd_pair
   task automatic t_basic();
      check("idle outputs", 8'h00, {5'h00, sdaOe, busFault, regWrPulse});
      rd_reg(8'h08, CFG_DEFAULT0);
      wr_reg(8'h08, 8'h3C);
      check("write count", 8'h01, 8'(wrCount));
      check("write index", 8'h08, regWrIndex);
      check("write data", 8'h3C, regWrData);
      rd_reg(8'h08, 8'h3C);
      wr_reg(STATUS_IDX, 8'hFF);
      check("read-only write", 8'h01, 8'(wrCount));
      $display("done basic");
   endtask : t_basic
   task automatic t_foreign();
      logic a;
      logic [6:0] addrs [2] = '{ADDR_OPT1, 7'h25};
      int oe0;
      oe0 = oeCount;
      foreach (addrs[i]) begin
         host_i.start();
         host_i.send_byte({addrs[i], 1'b0}, a);
         host_i.stop();
         check("foreign ack", 8'h01, {7'h00, a});
      end
      check("foreign drive", 8'h00, (oeCount != oe0) ? 8'h01 : 8'h00);
      $display("done foreign");
   endtask : t_foreign
   task automatic t_abort_glitch();
      logic a, u;
      host_i.start();
      host_i.send_byte({devAddr, 1'b0}, a);
      host_i.send_byte(8'h0A, a);
      for (int i = 0; i < 4; i++) host_i.bit_cycle(i[0], u);
      wr_reg(8'h0B, 8'h77);
      check("abort count", 8'h02, 8'(wrCount));
      check("abort index", 8'h0B, regWrIndex);
      host_i.start();
      host_i.send_byte({devAddr, 1'b0}, a);
      host_i.send_byte(8'h0C, a);
      host_i.glitch_scl();
      host_i.send_byte(8'h81, a);
      host_i.stop();
      check("glitch ack", 8'h00, {7'h00, a});
      check("glitch data", 8'h81, regWrData);
      $display("done abort glitch");
   endtask : t_abort_glitch
   task automatic t_timeout();
      logic a;
      host_i.start();
      host_i.send_byte({devAddr, 1'b0}, a);
      host_i.hold(TO_CYC + 100);
      check("fault set", 8'h01, {7'h00, busFault});
      host_i.send_byte(8'h06, a);
      host_i.stop();
      check("idle after timeout", 8'h01, {7'h00, a});
      rd_reg(STATUS_IDX, {7'h55, 1'b1});
      rd_pair(STATUS_IDX, {7'h55, 1'b0}, BASIC_DEFAULT);
      $display("done timeout");
   endtask : t_timeout
   task automatic t_states();
      logic a;
      chgRst = 1'b1;
      host_i.start();
      host_i.send_byte({devAddr, 1'b0}, a);
      host_i.stop();
      check("reset state ack", 8'h01, {7'h00, a});
      chgRst = 1'b0;
      host_i.start();
      host_i.send_byte({devAddr, 1'b0}, a);
      host_i.send_byte(8'h0D, a);
      supLoss = 1'b1;
      host_i.hold(5);
      supLoss = 1'b0;
      host_i.send_byte(8'h12, a);
      host_i.stop();
      check("supply loss ack", 8'h01, {7'h00, a});
      check("supply loss write", 8'h03, 8'(wrCount));
      $display("done states");
   endtask : t_states
   task automatic t_variant();
      logic a;
      do_reset(1'b1);
      devAddr = ADDR_OPT1;
      host_i.start();
      host_i.send_byte({ADDR_OPT0, 1'b0}, a);
      host_i.stop();
      check("other option ack", 8'h01, {7'h00, a});
      rd_reg(8'h08, CFG_DEFAULT1);
      check("drive level", 8'h00, {7'h00, outBad});
      $display("done variant");
   endtask : t_variant
   task automatic stop_test();
      $display("compares %0d numErrors %0d", compares, numErrors);
      if (numErrors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   initial begin
      rst = 1'b1;
      strap = 1'b0;
      chgRst = 1'b0;
      supLoss = 1'b0;
      devAddr = ADDR_OPT0;
      do_reset(1'b0);
      t_basic();
      t_foreign();
      t_abort_glitch();
      t_timeout();
      t_states();
      t_variant();
      stop_test();
   end
   // run is about 94k cycles; a hang ends here
   initial begin
      repeat (100000) @(posedge sys_clk);
      numErrors++;
      stop_test();
   end
endmodule : charger_i2c_slave_port_tb
